/* stl_if.sv */
// carriers between the front-panel top and its helper modules
// assumes all users sit on the same clock
`timescale 1ns/1ps

interface stl_pin_if import stl_pkg::*; ();
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] level;
  logic [SYNC_W-1:0] fall;
  modport sync (input raw, output level, output fall);
  modport user (output raw, input level, input fall);
endinterface

interface stl_tmr_if;
  logic start;
  logic busy;
  modport timer (input start, output busy);
  modport user (output start, input busy);
endinterface

/* stl_master_model.sv */
// network master stand-in: one poll pulse per bench request, gathers words
// assumes the slave answers on the same clock within a few cycles
`timescale 1ns/1ps

module stl_master_model import stl_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench command
  input wire logic poll_go,
  // slave side
  output logic net_poll,
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  // gathered data
  output logic [31:0] rx_word,
  output logic [7:0] rx_cnt
);
  // this slave gets its turn only when the bench asks for a poll
  always_ff @(posedge clk) begin
    if (rst) begin
      net_poll <= 1'b0;
      rx_word <= ZERO32;
      rx_cnt <= 8'h00;
    end else begin
      net_poll <= poll_go;
      if (tx_valid) begin
        rx_word <= tx_data;
        rx_cnt <= rx_cnt + 8'h01;
      end
    end
  end
endmodule // stl_master_model

/* stl_panel.sv */
// front-panel status: power and network indicators, display menu
// assumes an APB master on REF_CLK and decoder/network logic on REF_CLK
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps

module stl_panel import stl_pkg::*; #(
  parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYC,
  parameter int unsigned READ_OFF_CYCLES = READ_OFF_CYC,
  parameter int unsigned BACKLIGHT_CYCLES = BACKLIGHT_CYC
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // decoder and self-test
  input wire logic SELFTEST_DONE,
  input wire logic SELFTEST_OK,
  input wire logic GOOD_READ,
  // polling slave
  input wire logic NET_INIT,
  input wire logic NET_COMM_ERR,
  input wire logic NET_LINK_LOST,
  input wire logic NET_POLL,
  output logic TX_VALID,
  output logic [31:0] TX_DATA,
  // operator pins
  input wire logic BTN_ENTER_N,
  input wire logic BTN_DOWN_N,
  input wire logic [ADDR_W-1:0] ADDR_SW,
  // indicators
  output logic POWER_INDICATOR,
  output logic NET_LED_GREEN,
  output logic NET_LED_RED,
  // display
  output logic [2:0] DISP_FUNC,
  output logic [31:0] DISP_VALUE,
  output logic DISP_FLASH,
  output logic DISP_ON,
  output logic BACKLIGHT,
  output logic SLAVE_MODE
);

  typedef struct packed {
    stl_func_e func;
    logic chg_mode;
    logic [31:0] blink_cnt;
    logic blink;
    logic read_en;
    logic [31:0] result;
    logic [QUAL_W-1:0] live_q;
    logic [QUAL_W-1:0] last_q;
    logic [ERR_W-1:0] errcode;
    logic [1:0] io;
    logic [31:0] tx_word;
    logic tx_pending;
    logic tx_valid;
    logic [31:0] tx_data;
    logic [31:0] prdata;
    logic [31:0] disp_value;
  } stl_panel_s;

  stl_panel_s st;
  stl_panel_s next_st;

  stl_pin_if pins ();
  stl_tmr_if off_tmr ();
  stl_tmr_if bl_tmr ();

  stl_pin_sync u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .pins(pins)
  );

  stl_timer #(.CYCLES(READ_OFF_CYCLES)) u_off (
    .clk(REF_CLK),
    .rst(RST),
    .tmr(off_tmr)
  );

  stl_timer #(.CYCLES(BACKLIGHT_CYCLES)) u_bl (
    .clk(REF_CLK),
    .rst(RST),
    .tmr(bl_tmr)
  );

  logic press_enter;
  logic press_down;
  logic [ADDR_W-1:0] addr;
  logic slave;
  logic ready;
  logic apb_wr;
  logic apb_setup;

  assign pins.raw = {ADDR_SW, BTN_DOWN_N, BTN_ENTER_N};
  assign press_enter = pins.fall[BTN_ENTER_BIT];
  assign press_down = pins.fall[BTN_DOWN_BIT];
  assign addr = pins.level[ADDR_LSB +: ADDR_W];
  assign slave = (addr != MASTER_ADDR);
  assign ready = SELFTEST_DONE & SELFTEST_OK & st.read_en;
  assign apb_wr = PSEL & PENABLE & PWRITE;
  assign apb_setup = PSEL & ~PENABLE;

  assign off_tmr.start = GOOD_READ & ready;
  assign bl_tmr.start = press_enter | press_down;

  always_comb begin
    next_st = st;
    next_st.tx_valid = 1'b0;

    // shared blink phase for indicators and flashing display
    if (st.blink_cnt >= 32'(BLINK_CYCLES - 1)) begin
      next_st.blink_cnt = ZERO32;
      next_st.blink = ~st.blink;
    end else begin
      next_st.blink_cnt = st.blink_cnt + 32'h0000_0001;
    end

    // menu navigation
    if (press_enter) begin
      next_st.chg_mode = ~st.chg_mode;
    end
    if (press_down && st.chg_mode) begin
      next_st.func = stl_next_func(st.func);
    end

    if (GOOD_READ) begin
      next_st.last_q = st.live_q;
    end

    // scan data leaves only on a poll addressed to this slave
    if (NET_POLL && slave && st.tx_pending) begin
      next_st.tx_valid = 1'b1;
      next_st.tx_data = st.tx_word;
      next_st.tx_pending = 1'b0;
    end

    // register writes; a new tx word wins over a send in the same cycle
    if (apb_wr) begin
      case (PADDR)
        REG_CTRL: next_st.read_en = PWDATA[CTRL_READ_EN];
        REG_RESULT: next_st.result = PWDATA;
        REG_QUALITY: next_st.live_q = PWDATA[QUAL_W-1:0];
        REG_ERRCODE: next_st.errcode = PWDATA[ERR_W-1:0];
        REG_IOSTATE: next_st.io = PWDATA[1:0];
        REG_TXDATA: begin
          next_st.tx_word = PWDATA;
          next_st.tx_pending = 1'b1;
        end
        default: ;
      endcase
    end

    // read data is captured in the setup phase
    if (apb_setup) begin
      case (PADDR)
        REG_CTRL: next_st.prdata = {31'h0000_0000, st.read_en};
        REG_RESULT: next_st.prdata = st.result;
        REG_QUALITY: next_st.prdata = {25'h000_0000, st.live_q};
        REG_ERRCODE: next_st.prdata = {16'h0000, st.errcode};
        REG_IOSTATE: next_st.prdata = {30'h0000_0000, st.io};
        REG_STATUS: next_st.prdata = {12'h000, st.last_q, addr,
          st.tx_pending, ready, slave, bl_tmr.busy, st.chg_mode, st.func};
        default: next_st.prdata = ZERO32;
      endcase
    end

    // bottom line value for the selected function
    case (st.func)
      FN_READ: next_st.disp_value = st.result;
      FN_QUAL: next_st.disp_value = {25'h000_0000, st.last_q};
      FN_INFO: next_st.disp_value = {16'h0000, st.errcode};
      FN_IO: next_st.disp_value =
        {30'h0000_0000, st.io[IO_IN], st.io[IO_OUT]};
      FN_ADDR: next_st.disp_value = {27'h000_0000, addr};
      FN_ADJ: next_st.disp_value = {25'h000_0000, st.live_q};
      FN_VER: next_st.disp_value = {SW_VERSION, HW_VERSION};
      default: next_st.disp_value = ZERO32;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st <= '0;
      st.func <= FN_READ;
    end else begin
      st <= next_st;
    end
  end

  // apb answers with no wait states
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~stl_reg_hit(PADDR);
  assign PRDATA = st.prdata;

  assign TX_VALID = st.tx_valid;
  assign TX_DATA = st.tx_data;

  // power indicator: blink while starting, steady when ready
  assign POWER_INDICATOR = ready ? ~off_tmr.busy :
    (~SELFTEST_DONE & st.blink);

  // network indicator: lost delivery beats the error blink
  assign NET_LED_RED = NET_LINK_LOST |
    (NET_INIT & NET_COMM_ERR & st.blink);
  assign NET_LED_GREEN = slave & NET_INIT & ~NET_COMM_ERR & ~NET_LINK_LOST;

  // two-line screen: function code on top, value below
  assign DISP_FUNC = st.func;
  assign DISP_VALUE = st.disp_value;
  assign DISP_FLASH = st.chg_mode;
  assign DISP_ON = ~st.chg_mode | st.blink;
  assign BACKLIGHT = bl_tmr.busy;
  assign SLAVE_MODE = slave;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_down_in_mode;
    st.chg_mode && press_down && !press_enter;
  endsequence

  sequence s_advance;
    st.func == stl_next_func($past(st.func));
  endsequence

  property p_pwr_blink;
    !SELFTEST_DONE |-> POWER_INDICATOR == st.blink;
  endproperty
  a_pwr_blink: assert property (p_pwr_blink)
    else $error("power indicator not blinking during start-up");

  property p_pwr_steady;
    ready && !off_tmr.busy |-> POWER_INDICATOR;
  endproperty
  a_pwr_steady: assert property (p_pwr_steady)
    else $error("power indicator not steady when ready");

  property p_good_read;
    ready && GOOD_READ ##1 ready |-> !POWER_INDICATOR;
  endproperty
  a_good_read: assert property (p_good_read)
    else $error("good read did not blank the power indicator");

  property p_net_steady;
    NET_LINK_LOST [*2] |-> NET_LED_RED && !NET_LED_GREEN;
  endproperty
  a_net_steady: assert property (p_net_steady)
    else $error("network indicator not steady red on lost link");

  property p_net_blink;
    NET_INIT && NET_COMM_ERR && !NET_LINK_LOST |-> NET_LED_RED == st.blink;
  endproperty
  a_net_blink: assert property (p_net_blink)
    else $error("network indicator not blinking on comm error");

  property p_reset_func;
    $past(RST) |-> st.func == FN_READ && !st.chg_mode;
  endproperty
  a_reset_func: assert property (p_reset_func)
    else $error("read result not selected after reset");

  property p_toggle;
    press_enter |=> st.chg_mode != $past(st.chg_mode);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("confirm press did not toggle change mode");

  property p_advance;
    s_down_in_mode |=> s_advance;
  endproperty
  a_advance: assert property (p_advance)
    else $error("down press did not advance the function");

  property p_wrap;
    s_down_in_mode ##0 st.func == FN_VER |=> st.func == FN_READ;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("selection did not wrap to read result");

  property p_backlight;
    (press_enter || press_down) |=> BACKLIGHT [*2];
  endproperty
  a_backlight: assert property (p_backlight)
    else $error("backlight not lit after button press");

  property p_addr_value;
    st.func == FN_ADDR && $stable(addr) |=>
      DISP_VALUE == {27'h000_0000, $past(addr)};
  endproperty
  a_addr_value: assert property (p_addr_value)
    else $error("station address not shown");

  property p_tx_on_poll;
    TX_VALID |-> $past(NET_POLL) && $past(slave);
  endproperty
  a_tx_on_poll: assert property (p_tx_on_poll)
    else $error("scan data sent without a poll");

  property p_tx_data;
    TX_VALID |-> TX_DATA == $past(st.tx_word);
  endproperty
  a_tx_data: assert property (p_tx_data)
    else $error("sent word differs from the loaded word");

  property p_down_ignored;
    press_down && !st.chg_mode |=> $stable(st.func);
  endproperty
  a_down_ignored: assert property (p_down_ignored)
    else $error("down press changed the function outside change mode");

  property p_last_q;
    GOOD_READ |=> st.last_q == $past(st.live_q);
  endproperty
  a_last_q: assert property (p_last_q)
    else $error("decode quality not latched on a good read");

  property p_master_addr;
    addr == MASTER_ADDR |-> !SLAVE_MODE;
  endproperty
  a_master_addr: assert property (p_master_addr)
    else $error("slave operation with the master address");

endmodule // stl_panel

/* stl_panel_tb.sv */
// self-checking bench for the front-panel block
// assumes short blink, read-off and backlight counts set below
`timescale 1ns/1ps

module stl_panel_tb import stl_pkg::*;;
  localparam int BL = 8;
  localparam int RO = 4;
  localparam int BK = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = ZERO32;
  logic st_done = 1'b0;
  logic st_ok = 1'b0;
  logic good_read = 1'b0;
  logic net_init = 1'b0;
  logic net_err = 1'b0;
  logic net_lost = 1'b0;
  logic poll_go = 1'b0;
  logic btn_enter_n = 1'b1;
  logic btn_down_n = 1'b1;
  logic [ADDR_W-1:0] addr_sw = 5'h00;
  logic [31:0] prdata, tx_data, disp_value, rx_word;
  logic pready, pslverr, tx_valid, net_poll, pwr_ind, led_red;
  logic disp_flash, disp_on, backlight, slave_mode, led_green;
  logic [2:0] disp_func;
  logic [7:0] rx_cnt;
  int n_fail = 0;
  int checked = 0;

  always #5 clk = ~clk;

  stl_panel #(.BLINK_CYCLES(BL), .READ_OFF_CYCLES(RO),
    .BACKLIGHT_CYCLES(BK)) i_stl_panel (
    .REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SELFTEST_DONE(st_done),
    .SELFTEST_OK(st_ok), .GOOD_READ(good_read), .NET_INIT(net_init),
    .NET_COMM_ERR(net_err), .NET_LINK_LOST(net_lost),
    .NET_POLL(net_poll), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .BTN_ENTER_N(btn_enter_n), .BTN_DOWN_N(btn_down_n),
    .ADDR_SW(addr_sw), .POWER_INDICATOR(pwr_ind), .NET_LED_GREEN(led_green),
    .NET_LED_RED(led_red), .DISP_FUNC(disp_func),
    .DISP_VALUE(disp_value), .DISP_FLASH(disp_flash), .DISP_ON(disp_on),
    .BACKLIGHT(backlight), .SLAVE_MODE(slave_mode));

  stl_master_model i_stl_master_model (
    .clk(clk), .rst(rst), .poll_go(poll_go), .net_poll(net_poll),
    .tx_valid(tx_valid), .tx_data(tx_data), .rx_word(rx_word),
    .rx_cnt(rx_cnt));

  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // apb master: holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  // counts cycles with the chosen indicator lit
  task automatic hi_count(input int sel, input int n, output int hi);
    logic v;
    hi = 0;
    repeat (n) begin
      @(negedge clk);
      case (sel)
        0: v = pwr_ind;
        1: v = led_red;
        default: v = disp_on;
      endcase
      hi += int'(v === 1'b1);
    end
    @(posedge clk);
  endtask

  task automatic press(input int down);
    @(posedge clk);
    if (down) btn_down_n <= 1'b0;
    else btn_enter_n <= 1'b0;
    repeat (8) @(posedge clk);
    btn_down_n <= 1'b1;
    btn_enter_n <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic do_poll();
    @(posedge clk);
    poll_go <= 1'b1;
    @(posedge clk);
    poll_go <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic e;
    apb(1'b0, REG_CTRL, ZERO32, q, e);
    chk("ctrl reset", ZERO32, q);
    wr(REG_ERRCODE, 32'h0000_3201);
    apb(1'b0, REG_ERRCODE, ZERO32, q, e);
    chk("errcode", 32'h0000_3201, q);
    apb(1'b0, 8'h40, ZERO32, q, e);
    chk("unmapped err", 32'h0000_0001, 32'(e));
    chk("unmapped data", ZERO32, q);
    wr(REG_RESULT, 32'h8877_6655);
    wr(REG_IOSTATE, 32'h0000_0001);
  endtask

  task automatic t_power();
    int hi;
    hi_count(0, 4 * BL, hi);
    chk("pwr blink", 32'h1, 32'(hi > 0 && hi < 4 * BL));
    st_done <= 1'b1;
    st_ok <= 1'b1;
    wr(REG_QUALITY, 32'h0000_0054);
    wr(REG_CTRL, 32'h0000_0001);
    hi_count(0, 4 * BL, hi);
    chk("pwr steady", 32'(4 * BL), 32'(hi));
    good_read <= 1'b1;
    @(posedge clk);
    good_read <= 1'b0;
    hi_count(0, 2 * RO, hi);
    chk("pwr good read", 32'(RO), 32'(hi));
    wr(REG_QUALITY, 32'h0000_0049);
  endtask

  task automatic t_tx();
    @(negedge clk);
    chk("slave addr0", ZERO32, 32'(slave_mode));
    wr(REG_TXDATA, 32'hA5A5_0001);
    do_poll();
    chk("no answer addr0", ZERO32, 32'(rx_cnt));
    @(posedge clk);
    addr_sw <= 5'h19;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("slave addr25", 32'h1, 32'(slave_mode));
    wr(REG_TXDATA, 32'h8877_6655);
    do_poll();
    chk("tx count", 32'h1, 32'(rx_cnt));
    chk("tx word", 32'h8877_6655, rx_word);
    do_poll();
    chk("idle poll", 32'h1, 32'(rx_cnt));
  endtask

  task automatic t_net();
    int hi;
    @(posedge clk);
    net_init <= 1'b1;
    net_err <= 1'b1;
    hi_count(1, 4 * BL, hi);
    chk("red blink", 32'h1, 32'(hi > 0 && hi < 4 * BL));
    net_lost <= 1'b1;
    hi_count(1, 4 * BL, hi);
    chk("red steady", 32'(4 * BL), 32'(hi));
    @(negedge clk);
    chk("green while lost", ZERO32, 32'(led_green));
    @(posedge clk);
    net_err <= 1'b0;
    net_lost <= 1'b0;
    @(negedge clk);
    chk("green when clear", 32'h1, 32'(led_green));
  endtask

  task automatic t_menu();
    logic [31:0] v [7];
    int hi;
    int k;
    v = '{32'h8877_6655, 32'h0000_0054, 32'h0000_3201, 32'h0000_0001,
      32'h0000_0019, 32'h0000_0049, {SW_VERSION, HW_VERSION}};
    press(0);
    chk("flash on", 32'h1, 32'(disp_flash));
    chk("value read", v[0], disp_value);
    hi_count(2, 4 * BL, hi);
    chk("display flashing", 32'h1, 32'(hi > 0 && hi < 4 * BL));
    for (int i = 1; i <= 7; i++) begin
      k = i % 7;
      press(1);
      chk("func", 32'(k), 32'(disp_func));
      chk("value", v[k], disp_value);
    end
    repeat (3) press(1);
    press(0);
    chk("flash off", ZERO32, 32'(disp_flash));
    chk("func kept", 32'h3, 32'(disp_func));
    hi_count(2, 4 * BL, hi);
    chk("display steady", 32'(4 * BL), 32'(hi));
  endtask

  task automatic t_light();
    repeat (BK + 10) @(posedge clk);
    press(1);
    chk("light on", 32'h1, 32'(backlight));
    press(1);
    chk("light restart", 32'h1, 32'(backlight));
    chk("down ignored", 32'h3, 32'(disp_func));
    repeat (BK) @(posedge clk);
    @(negedge clk);
    chk("light off", ZERO32, 32'(backlight));
  endtask

  // second reset in mid-run: menu must come back on read result
  task automatic t_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("func after reset", ZERO32, 32'(disp_func));
    chk("flash after reset", ZERO32, 32'(disp_flash));
    chk("value after reset", ZERO32, disp_value);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("func reset", ZERO32, 32'(disp_func));
    chk("light reset", ZERO32, 32'(backlight));
    t_regs();
    t_power();
    t_tx();
    t_net();
    t_menu();
    t_light();
    t_reset();
    final_report();
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    final_report();
  end
endmodule // stl_panel_tb

/* stl_pin_sync.sv */
// three-stage synchroniser for buttons and address switch
// assumes raw pins are asynchronous to REF_CLK
`timescale 1ns/1ps

module stl_pin_sync import stl_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins
  stl_pin_if.sync pins
);

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] level;
    logic [SYNC_W-1:0] fall;
  } stl_sync_s;

  stl_sync_s st;
  stl_sync_s next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pins.raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < SYNC_W; i++) begin
      // accept a new level only once stages two and three agree
      if (st.s2[i] == st.s3[i]) begin
        next_st.level[i] = st.s3[i];
      end
      next_st.fall[i] = st.level[i] & ~next_st.level[i];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '1;
      st.fall <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pins.level = st.level;
  assign pins.fall = st.fall;

endmodule // stl_pin_sync

/* stl_pkg.sv */
// shared constants, types and decode helpers for the front-panel block
// assumes a single 100 MHz clock shared by every module of the block
package stl_pkg;

  // clock rate and time figures
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned READ_OFF_MS = 100;
  localparam int unsigned BACKLIGHT_MS = 10000;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
  localparam int unsigned READ_OFF_CYC = READ_OFF_MS * 1000 * CLK_MHZ;
  localparam int unsigned BACKLIGHT_CYC = BACKLIGHT_MS * 1000 * CLK_MHZ;

  // screen geometry
  localparam int unsigned DISP_W = 128;
  localparam int unsigned DISP_H = 32;

  // synchronised pins: two buttons then the address switch
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned SYNC_W = 2 + ADDR_W;
  localparam int unsigned BTN_ENTER_BIT = 0;
  localparam int unsigned BTN_DOWN_BIT = 1;
  localparam int unsigned ADDR_LSB = 2;
  localparam logic [ADDR_W-1:0] MASTER_ADDR = 5'h00;
  localparam int unsigned MAX_SLAVES = 31;

  // version words, values arbitrary
  localparam logic [15:0] SW_VERSION = 16'h0001;
  localparam logic [15:0] HW_VERSION = 16'h0001;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RESULT = 8'h04;
  localparam logic [7:0] REG_QUALITY = 8'h08;
  localparam logic [7:0] REG_ERRCODE = 8'h0C;
  localparam logic [7:0] REG_IOSTATE = 8'h10;
  localparam logic [7:0] REG_TXDATA = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // field layout
  localparam int unsigned CTRL_READ_EN = 0;
  localparam int unsigned QUAL_W = 7;
  localparam int unsigned ERR_W = 16;
  localparam int unsigned IO_OUT = 0;
  localparam int unsigned IO_IN = 1;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  typedef enum logic [2:0] {
    FN_READ, FN_QUAL, FN_INFO, FN_IO, FN_ADDR, FN_ADJ, FN_VER
  } stl_func_e;

  // next display function, wrapping after version
  function automatic stl_func_e stl_next_func(input stl_func_e f);
    case (f)
      FN_READ: stl_next_func = FN_QUAL;
      FN_QUAL: stl_next_func = FN_INFO;
      FN_INFO: stl_next_func = FN_IO;
      FN_IO: stl_next_func = FN_ADDR;
      FN_ADDR: stl_next_func = FN_ADJ;
      FN_ADJ: stl_next_func = FN_VER;
      default: stl_next_func = FN_READ;
    endcase
  endfunction

  // true for every mapped register offset
  function automatic logic stl_reg_hit(input logic [7:0] a);
    stl_reg_hit = (a == REG_CTRL) || (a == REG_RESULT) ||
      (a == REG_QUALITY) || (a == REG_ERRCODE) || (a == REG_IOSTATE) ||
      (a == REG_TXDATA) || (a == REG_STATUS);
  endfunction

endpackage

/* stl_timer.sv */
// retriggerable one-shot: busy for CYCLES clocks after the last start
// assumes start is a one-cycle pulse on the same clock
`timescale 1ns/1ps

module stl_timer #(
  parameter int unsigned CYCLES = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  stl_tmr_if.timer tmr
);

  typedef struct packed {
    logic [31:0] cnt;
    logic busy;
  } stl_tmr_s;

  stl_tmr_s st;
  stl_tmr_s next_st;

  always_comb begin
    next_st = st;
    if (tmr.start) begin
      next_st.cnt = 32'(CYCLES - 1);
      next_st.busy = 1'b1;
    end else if (st.cnt != 32'h0000_0000) begin
      next_st.cnt = st.cnt - 32'h0000_0001;
    end else begin
      next_st.busy = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tmr.busy = st.busy;

endmodule // stl_timer
